// [core/rfsw_pkg.sv]
// package: fault word bit positions, modes and reset values
package rfsw_pkg;
  localparam int WORD_W = 32;
  // newer layout bit positions
  localparam int NB_SINCOS1    = 0;
  localparam int NB_SINCOS2    = 1;
  localparam int NB_SUPPLY     = 2;
  localparam int NB_POSITION   = 3;
  localparam int NB_OVERLAP    = 7;
  localparam int NB_TEMP       = 8;
  localparam int NB_DOUT_RB    = 9;
  localparam int NB_ANALOG     = 10;
  localparam int NB_RELAY_RB   = 11;
  localparam int NB_INPUT      = 13;
  localparam int NB_PHASE1     = 16;
  localparam int NB_PHASE2     = 17;
  localparam int NB_FREQ       = 18;
  localparam int NB_DRIFT1     = 19;
  localparam int NB_DRIFT2     = 20;
  localparam int NB_ISM        = 21;
  localparam int NB_EXT_RELAY  = 22;
  localparam int NB_ERRSIM     = 23;
  localparam int NB_REGISTER   = 24;
  localparam int NB_CYCLE      = 25;
  localparam int NB_EXT_CLOCK  = 26;
  localparam int NB_OVERFLOW   = 27;
  localparam int NB_ADC        = 28;
  localparam int NB_I2C        = 29;
  localparam int NB_INIT_TEST  = 30;
  // older layout positions that differ
  localparam int OB_SUPPLY1    = 2;
  localparam int OB_SUPPLY2    = 3;
  localparam int OB_SUPPLY_DU  = 4;
  localparam int OB_AOUT_SEQ   = 10;
  localparam int OB_AOUT_RB    = 12;
  localparam int OB_CONV_SEQ   = 14;
  localparam int OB_CONV_OUT   = 15;
  // comparison modes
  localparam logic [1:0] CMP_MODE_0 = 2'h0;
  localparam logic [1:0] CMP_MODE_1 = 2'h1;
  localparam logic [1:0] CMP_MODE_2 = 2'h2;
  // error simulation value meaning normal
  localparam logic [1:0] ERRSIM_NORMAL = 2'h1;
  // reset values
  localparam logic [WORD_W-1:0] FAULT_RST = 32'h0000_0000;
  localparam logic [1:0] SYNC_RST = 2'h0;
  // layout select
  typedef enum logic [0:0] {
    RFSW_LAYOUT_OLD = 1'b0,
    RFSW_LAYOUT_NEW = 1'b1
  } rfsw_layout_e;
endpackage : rfsw_pkg

// [core/rfsw_safe_out.sv]
// error-state output stage: forces outputs to their safe values
module rfsw_safe_out #(
  parameter int DOUT_N = 4,
  parameter int AOUT_W = 12
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              error_state,
  input  wire logic [DOUT_N-1:0] dout_cmd,
  input  wire logic              relay_cmd,
  input  wire logic [AOUT_W-1:0] aout_cmd,
  output logic      [DOUT_N-1:0] dout_p,
  output logic      [DOUT_N-1:0] dout_n,
  output logic                   relay_close,
  output logic      [AOUT_W-1:0] aout_code
);
  import rfsw_pkg::*;
  typedef struct packed {
    logic [DOUT_N-1:0] p;
    logic [DOUT_N-1:0] n;
    logic              rly;
    logic [AOUT_W-1:0] ao;
  } rfsw_so_s;
  rfsw_so_s st_r;
  rfsw_so_s st_nxt;

  if (DOUT_N < 1 || AOUT_W < 1) begin : g_bad_w
    $error("rfsw_safe_out: bad width");
  end

  // error state: both channels low, relay open, current code zero
  always_comb begin
    st_nxt = st_r;
    if (error_state) begin
      st_nxt.p   = '0;
      st_nxt.n   = '0;
      st_nxt.rly = 1'b0;
      st_nxt.ao  = '0;
    end else begin
      st_nxt.p   = dout_cmd;
      st_nxt.n   = ~dout_cmd;
      st_nxt.rly = relay_cmd;
      st_nxt.ao  = aout_cmd;
    end
  end

  // reset lands in the safe state, not the commanded one
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout_p      = st_r.p;
  assign dout_n      = st_r.n;
  assign relay_close = st_r.rly;
  assign aout_code   = st_r.ao;
endmodule : rfsw_safe_out

// [core/rfsw_sync.sv]
// two-flop synchroniser for detector inputs from outside the clock domain
module rfsw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import rfsw_pkg::*;
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rfsw_sync_s;
  rfsw_sync_s st_r;
  rfsw_sync_s st_nxt;

  if (W < 1) begin : g_bad_w
    $error("rfsw_sync: width must be positive");
  end

  // first stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : rfsw_sync

// [core/rfsw_top.sv]
// runtime fault status word: sticky fault collection and error state
// Operation
// - newer layout: encoder sincos faults bits 0,1
// - newer layout: any supply fault bit 2
// - newer layout: position fault bit 3, only in modes 1, 2
// - frequency mismatch bit 18; newer: modes 0,2
// - temperature bit 8, newer overlap bit 7
// - digital output readback fault bit 9
// - relay drive/readback fault bit 11
// - illegal input combination bit 13
// - encoder sequence faults bits 16, 17
// - encoder drift faults bits 19, 20
// - external relay feedback fault bit 22
// - error simulation not 1 in normal mode
// - sampling overflow fault bit 27
// - any power-up self-test fault sets bit 30
// - older layout: supplies at bits 2,3,4
// - older layout: analog faults bits 10, 12
// - older layout: converter faults bits 14, 15
// - error state: outputs low, relay open, 0 mA
// - cleared only by reset or commissioning clear
module rfsw_top #(
  parameter int DOUT_N = 4,
  parameter int AOUT_W = 12,
  parameter int INIT_W = 15
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire rfsw_pkg::rfsw_layout_e     layout_sel,
  input  wire logic [1:0]                 cmp_mode,
  input  wire logic [1:0]                 errsim_param,
  input  wire logic                       normal_mode_sw,
  input  wire logic                       commission_clear,
  input  wire logic                       sincos1_fault,
  input  wire logic                       sincos2_fault,
  input  wire logic                       supply1_fault,
  input  wire logic                       supply2_fault,
  input  wire logic                       supply_du_fault,
  input  wire logic                       position_fault,
  input  wire logic                       overlap_fault,
  input  wire logic                       temp_fault,
  input  wire logic                       analog_fault,
  input  wire logic                       aout_rb_fault,
  input  wire logic                       conv_seq_fault,
  input  wire logic                       conv_out_fault,
  input  wire logic                       input_plausibility_fault,
  input  wire logic                       phase1_fault,
  input  wire logic                       phase2_fault,
  input  wire logic                       drift1_fault,
  input  wire logic                       drift2_fault,
  input  wire logic                       internal_state_machine_fault,
  input  wire logic                       external_relay_feedback_fault,
  input  wire logic                       register_fault,
  input  wire logic                       timing_cycle_fault,
  input  wire logic                       ext_clock_fault,
  input  wire logic                       sampling_overflow,
  input  wire logic                       adc_fault,
  input  wire logic                       i2c_fault,
  input  wire logic                       channel_a_freq_valid,
  input  wire logic [15:0]                channel_a_frequency,
  input  wire logic [15:0]                channel_b_frequency,
  input  wire logic [INIT_W-1:0]          init_test_faults,
  input  wire logic [DOUT_N-1:0]          dout_cmd,
  input  wire logic [DOUT_N-1:0]          dout_readback,
  input  wire logic                       relay_cmd,
  input  wire logic                       relay_drive_rb,
  input  wire logic                       relay_contact_rb,
  input  wire logic [AOUT_W-1:0]          aout_cmd,
  output logic      [rfsw_pkg::WORD_W-1:0] fault_word,
  output logic                            error_state,
  output logic      [DOUT_N-1:0]          dout_p,
  output logic      [DOUT_N-1:0]          dout_n,
  output logic                            relay_close,
  output logic      [AOUT_W-1:0]          aout_code
);
  import rfsw_pkg::*;

  localparam int NPIN = 27 + DOUT_N + 2 + 32;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              err;
    logic [1:0]        sim_bad;
    logic [1:0]        warm;    // synchroniser fill after reset
    logic [15:0]       fa_q;    // last synchronised channel a word
    logic [15:0]       fb_q;    // last synchronised channel b word
  } rfsw_top_s;

  rfsw_top_s st_r;
  rfsw_top_s st_nxt;

  // refuse widths the logic cannot serve
  if (DOUT_N < 1 || AOUT_W < 1) begin : g_bad_out_w
    $error("rfsw_top: bad output widths");
  end
  if (INIT_W < 1) begin : g_bad_init_w
    $error("rfsw_top: self-test list must not be empty");
  end

  // every detector, readback and frequency input passes two flops before the fault logic
  logic [NPIN-1:0] raw_in;
  logic [NPIN-1:0] syn_in;

  assign raw_in = {
    sincos1_fault,
    sincos2_fault,
    supply1_fault,
    supply2_fault,
    supply_du_fault,
    position_fault,
    overlap_fault,
    temp_fault,
    analog_fault,
    aout_rb_fault,
    conv_seq_fault,
    conv_out_fault,
    input_plausibility_fault,
    phase1_fault,
    phase2_fault,
    drift1_fault,
    drift2_fault,
    internal_state_machine_fault,
    external_relay_feedback_fault,
    register_fault,
    timing_cycle_fault,
    ext_clock_fault,
    sampling_overflow,
    adc_fault,
    i2c_fault,
    |init_test_faults,
    channel_a_freq_valid,
    dout_readback,
    relay_drive_rb,
    relay_contact_rb,
    channel_a_frequency,
    channel_b_frequency
  };

  rfsw_sync #(
    .W (NPIN)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    (raw_in),
    .q    (syn_in)
  );

  // unpack synchronised inputs, same order as above
  logic              s_sc1;
  logic              s_sc2;
  logic              s_sup1;
  logic              s_sup2;
  logic              s_supdu;
  logic              s_pos;
  logic              s_ovl;
  logic              s_tmp;
  logic              s_ana;
  logic              s_aorb;
  logic              s_cseq;
  logic              s_cout;
  logic              s_inp;
  logic              s_ph1;
  logic              s_ph2;
  logic              s_dr1;
  logic              s_dr2;
  logic              s_ism;
  logic              s_xrly;
  logic              s_reg;
  logic              s_cyc;
  logic              s_xclk;
  logic              s_ovf;
  logic              s_adc;
  logic              s_i2c;
  logic              s_init;
  logic              s_fvalid;
  logic              s_rdrv;
  logic              s_rcon;
  logic [DOUT_N-1:0] s_dorb;
  logic [15:0]       s_fa;
  logic [15:0]       s_fb;

  assign {s_sc1, s_sc2, s_sup1, s_sup2, s_supdu, s_pos, s_ovl, s_tmp,
          s_ana, s_aorb, s_cseq, s_cout, s_inp, s_ph1, s_ph2, s_dr1, s_dr2,
          s_ism, s_xrly, s_reg, s_cyc, s_xclk, s_ovf, s_adc, s_i2c, s_init,
          s_fvalid, s_dorb, s_rdrv, s_rcon, s_fa, s_fb} = syn_in;

  // mode gate: true when the comparison mode enables the check
  function automatic logic mode_in(input logic [1:0] m, input logic [1:0] a,
                                   input logic [1:0] b);
    mode_in = (m == a) || (m == b);
  endfunction : mode_in

  // new fault events this cycle, placed by layout
  logic [WORD_W-1:0] ev;
  logic              freq_diff;
  logic              dout_bad;
  logic              relay_bad;
  logic              is_new;

  // compare flags; readbacks wait until the synchroniser holds real samples,
  // else its reset zeros would latch a false readback fault
  always_comb begin
    is_new    = (layout_sel == RFSW_LAYOUT_NEW);
    // a 16-bit word is trusted only once two samples agree, bits cross unaligned
    freq_diff = s_fvalid && (s_fa == st_r.fa_q) && (s_fb == st_r.fb_q)
                && (s_fa != s_fb);
    dout_bad  = st_r.warm[1] && (s_dorb != dout_cmd);
    relay_bad = st_r.warm[1] && ((s_rdrv != relay_cmd) || (s_rcon != relay_cmd));
  end

  always_comb begin
    // shared bits, same place in both layouts
    ev = '0;
    ev[NB_SINCOS1]  = s_sc1;
    ev[NB_SINCOS2]  = s_sc2;
    ev[NB_TEMP]     = s_tmp;
    ev[NB_DOUT_RB]  = dout_bad;
    ev[NB_RELAY_RB] = relay_bad;
    ev[NB_INPUT]    = s_inp;
    ev[NB_PHASE1]   = s_ph1;
    ev[NB_PHASE2]   = s_ph2;
    ev[NB_DRIFT1]   = s_dr1;
    ev[NB_DRIFT2]   = s_dr2;
    ev[NB_ISM]      = s_ism;
    ev[NB_EXT_RELAY] = s_xrly;
    ev[NB_ERRSIM]   = st_r.sim_bad[1];
    ev[NB_REGISTER] = s_reg;
    ev[NB_CYCLE]    = s_cyc;
    ev[NB_EXT_CLOCK] = s_xclk;
    ev[NB_OVERFLOW] = s_ovf;
    ev[NB_ADC]      = s_adc;
    ev[NB_I2C]      = s_i2c;
    ev[NB_INIT_TEST] = s_init;
    // layout-specific placement
    if (is_new) begin
      ev[NB_SUPPLY]   = s_sup1 | s_sup2 | s_supdu;
      ev[NB_POSITION] = s_pos && mode_in(cmp_mode, CMP_MODE_1, CMP_MODE_2);
      ev[NB_OVERLAP]  = s_ovl;
      ev[NB_ANALOG]   = s_ana;
      ev[NB_FREQ]     = freq_diff && mode_in(cmp_mode, CMP_MODE_0, CMP_MODE_2);
    end else begin
      ev[OB_SUPPLY1]   = s_sup1;
      ev[OB_SUPPLY2]   = s_sup2;
      ev[OB_SUPPLY_DU] = s_supdu;
      ev[OB_AOUT_SEQ]  = s_ana;
      ev[OB_AOUT_RB]   = s_aorb;
      ev[OB_CONV_SEQ]  = s_cseq;
      ev[OB_CONV_OUT]  = s_cout;
      ev[NB_FREQ]      = freq_diff;
    end
  end

  // sticky word; events win over the commissioning clear
  always_comb begin
    st_nxt = st_r;
    // config is same-domain logic; pipelined two stages to match detector timing
    st_nxt.sim_bad = {st_r.sim_bad[0], normal_mode_sw && (errsim_param != ERRSIM_NORMAL)};
    // readback compares open once both synchroniser stages hold real samples
    st_nxt.warm    = {st_r.warm[0], 1'b1};
    st_nxt.fa_q    = s_fa;
    st_nxt.fb_q    = s_fb;
    if (commission_clear && !normal_mode_sw) begin
      st_nxt.word = ev;
    end else begin
      st_nxt.word = st_r.word | ev;
    end
    st_nxt.err = |st_nxt.word;
  end

  // only reset or commissioning clear removes a fault
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r.word    <= FAULT_RST;
      st_r.err     <= 1'b0;
      st_r.sim_bad <= SYNC_RST;
      st_r.warm    <= SYNC_RST;
      st_r.fa_q    <= '0;
      st_r.fb_q    <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // safe outputs follow the registered error state
  rfsw_safe_out #(
    .DOUT_N (DOUT_N),
    .AOUT_W (AOUT_W)
  ) u_out (
    .clk         (clk),
    .srst        (srst),
    .error_state (st_r.err),
    .dout_cmd    (dout_cmd),
    .relay_cmd   (relay_cmd),
    .aout_cmd    (aout_cmd),
    .dout_p      (dout_p),
    .dout_n      (dout_n),
    .relay_close (relay_close),
    .aout_code   (aout_code)
  );

  // word and error state leave straight from the state register
  assign fault_word  = st_r.word;
  assign error_state = st_r.err;
endmodule : rfsw_top

// [dv/rfsw_props.sv]
// checker: fault word stickiness, latency and error-state outputs
module rfsw_props #(
  parameter int DOUT_N = 4,
  parameter int AOUT_W = 12
) (
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic                        normal_mode_sw,
  input wire logic                        commission_clear,
  input wire logic [1:0]                  errsim_param,
  input wire logic                        temp_fault,
  input wire logic [DOUT_N-1:0]           dout_cmd,
  input wire logic                        relay_cmd,
  input wire logic [AOUT_W-1:0]           aout_cmd,
  input wire logic [rfsw_pkg::WORD_W-1:0] fault_word,
  input wire logic                        error_state,
  input wire logic [DOUT_N-1:0]           dout_p,
  input wire logic [DOUT_N-1:0]           dout_n,
  input wire logic                        relay_close,
  input wire logic [AOUT_W-1:0]           aout_code
);
  timeunit 1ns;
  timeprecision 1ps;
  import rfsw_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // error state must track the whole word, never a subset
  a_error_is_or: assert property (error_state == (|fault_word))
    else $error("error state differs from OR of fault word");
  // bits only fall through the commissioning clear
  a_bits_sticky: assert property (!$past(commission_clear && !normal_mode_sw)
    |-> (fault_word & $past(fault_word)) == $past(fault_word))
    else $error("fault bit dropped without clear");
  a_temp_latency: assert property (temp_fault |-> ##3 fault_word[NB_TEMP])
    else $error("temperature bit late");
  a_temp_cause: assert property ($rose(fault_word[NB_TEMP]) |-> $past(temp_fault, 3))
    else $error("temperature bit without cause");
  a_safe_outputs: assert property (error_state |=> dout_p == '0 && dout_n == '0
    && !relay_close && aout_code == '0)
    else $error("outputs not safe in error state");
  // sampled reset keeps the release edge, still resetting the outputs, out of it
  a_normal_pass: assert property (!srst && !error_state |=> dout_p == $past(dout_cmd)
    && dout_n == ~$past(dout_cmd) && relay_close == $past(relay_cmd)
    && aout_code == $past(aout_cmd))
    else $error("outputs not following commands");
  a_errsim_bit: assert property (normal_mode_sw && errsim_param != ERRSIM_NORMAL
    |-> ##[2:3] fault_word[NB_ERRSIM])
    else $error("error simulation bit missing");
  a_reset_clears: assert property ($fell(srst) |-> fault_word == FAULT_RST && !error_state)
    else $error("word not cleared by reset");
endmodule : rfsw_props

bind rfsw_top rfsw_props #(.DOUT_N(DOUT_N), .AOUT_W(AOUT_W)) rfsw_props_inst (
  .clk(clk), .srst(srst), .normal_mode_sw(normal_mode_sw),
  .commission_clear(commission_clear), .errsim_param(errsim_param),
  .temp_fault(temp_fault), .dout_cmd(dout_cmd), .relay_cmd(relay_cmd),
  .aout_cmd(aout_cmd), .fault_word(fault_word), .error_state(error_state),
  .dout_p(dout_p), .dout_n(dout_n), .relay_close(relay_close), .aout_code(aout_code));

// [dv/rfsw_reader.sv]
// display-side reader: shows the word and spots a fault that returns after restart
module rfsw_reader (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [31:0] fault_word,
  output logic      [31:0] shown_word = 32'h0,
  output logic             repeat_seen = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] before_reset = 32'h0;
  // word kept across the power cycle, so a returning fault means send back
  always @(posedge clk) begin
    if (srst && shown_word != 32'h0) before_reset <= shown_word;
    if (!srst) shown_word <= fault_word;
    if (!srst && before_reset != 32'h0 && fault_word == before_reset) repeat_seen <= 1'b1;
  end
endmodule : rfsw_reader

// [dv/tb_runtime_fault_status_word.sv]
// testbench: detector events mapped into the fault word in both layouts
module tb_runtime_fault_status_word;
  timeunit 1ns;
  timeprecision 1ps;
  import rfsw_pkg::*;
  logic         clk = 1'b0, srst = 1'b1, nsw = 1'b0, clr = 1'b0, fv = 1'b1;
  logic         rc = 1'b1, rdr = 1'b1, rcr = 1'b1, es, rl, rpt;
  rfsw_layout_e lay = RFSW_LAYOUT_NEW;
  logic [1:0]   cmp = 2'h1, esim = 2'h1;
  logic [24:0]  d = 25'h0;
  logic [15:0]  fa = 16'h1234, fb = 16'h1234;
  logic [14:0]  it = 15'h0;
  logic [3:0]   dc = 4'h5, drb = 4'h5, dp, dn;
  logic [11:0]  ac = 12'hABC, ao;
  logic [31:0]  fw, shown;
  int           err_count = 0, num_checks = 0;
  // -1 means dropped, -2 means not fixed for that layout
  int new_bit[25] = '{0,1,2,2,2,3,7,8,10,-2,-2,-2,13,16,17,19,20,21,22,24,25,26,27,28,29};
  int old_bit[25] = '{0,1,2,3,4,-2,-1,8,10,12,14,15,13,16,17,19,20,21,22,24,25,26,27,28,29};

  rfsw_top rfsw_top_inst (.clk(clk), .srst(srst), .layout_sel(lay), .cmp_mode(cmp),
    .errsim_param(esim), .normal_mode_sw(nsw), .commission_clear(clr),
    .sincos1_fault(d[0]), .sincos2_fault(d[1]), .supply1_fault(d[2]), .supply2_fault(d[3]),
    .supply_du_fault(d[4]), .position_fault(d[5]), .overlap_fault(d[6]), .temp_fault(d[7]),
    .analog_fault(d[8]), .aout_rb_fault(d[9]), .conv_seq_fault(d[10]),
    .conv_out_fault(d[11]), .input_plausibility_fault(d[12]), .phase1_fault(d[13]),
    .phase2_fault(d[14]), .drift1_fault(d[15]), .drift2_fault(d[16]),
    .internal_state_machine_fault(d[17]), .external_relay_feedback_fault(d[18]),
    .register_fault(d[19]), .timing_cycle_fault(d[20]), .ext_clock_fault(d[21]),
    .sampling_overflow(d[22]), .adc_fault(d[23]), .i2c_fault(d[24]),
    .channel_a_freq_valid(fv), .channel_a_frequency(fa), .channel_b_frequency(fb),
    .init_test_faults(it), .dout_cmd(dc), .dout_readback(drb), .relay_cmd(rc),
    .relay_drive_rb(rdr), .relay_contact_rb(rcr), .aout_cmd(ac), .fault_word(fw),
    .error_state(es), .dout_p(dp), .dout_n(dn), .relay_close(rl), .aout_code(ao));
  rfsw_reader rfsw_reader_inst (.clk(clk), .srst(srst), .fault_word(fw),
    .shown_word(shown), .repeat_seen(rpt));

  always #20 clk = ~clk;

  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // wait out the sync delay, compare, then clear through commissioning
  task automatic settle(logic [31:0] exp);
    step(5);
    #1;
    chk(fw, exp);
    chk({31'h0, es}, {31'h0, exp != 32'h0});
    chk(shown, exp);
    if (exp != 32'h0) chk(32'({dp, dn, rl, ao}), 32'h0);
    step(1);
    clr <= 1'b1;
    step(1);
    clr <= 1'b0;
    step(1);
    #1;
    chk(fw, 32'h0);
    step(1);
  endtask : settle

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // hang guard, far beyond the roughly 720 cycles the tests need
  initial begin
    step(20000);
    err_count++;
    give_verdict();
  end

  initial begin
    int b;
    step(20);
    srst <= 1'b0;
    step(3);
    for (int l = 0; l < 2; l++) for (int i = 0; i < 25; i++) begin
      b = (l == 1) ? new_bit[i] : old_bit[i];
      if (b != -2) begin
        lay <= rfsw_layout_e'(l);
        step(1);
        d[i] <= 1'b1;
        step(1);
        d[i] <= 1'b0;
        settle((b < 0) ? 32'h0 : (32'h1 << b));
      end
    end
    // comparison modes gate position and frequency checks in the newer layout
    for (int l = 0; l < 2; l++) for (int m = 0; m < 3; m++) begin
      lay <= rfsw_layout_e'(l);
      cmp <= 2'(m);
      step(1);
      d[5] <= 1'(l);
      fb <= 16'h1235;
      step(1);
      d[5] <= 1'b0;
      step(2);
      fb <= 16'h1234;
      settle(((l == 0 || m != 1) ? 32'h4_0000 : 32'h0) | ((l == 1 && m != 0) ? 32'h8 : 32'h0));
    end
    cmp <= 2'h1;
    it <= 15'h4000;
    step(1);
    it <= 15'h0;
    settle(32'h4000_0000);
    drb <= 4'h4;
    step(1);
    drb <= 4'h5;
    settle(32'h0000_0200);
    rdr <= 1'b0;
    step(1);
    rdr <= 1'b1;
    settle(32'h0000_0800);
    rcr <= 1'b0;
    step(1);
    rcr <= 1'b1;
    settle(32'h0000_0800);
    for (int v = 0; v < 4; v++) if (v != 1) begin
      nsw <= 1'b1;
      esim <= 2'(v);
      step(3);
      nsw <= 1'b0;
      esim <= ERRSIM_NORMAL;
      settle(32'h0080_0000);
    end
    // clear refused while the switches select normal operation
    d[7] <= 1'b1;
    step(1);
    d[7] <= 1'b0;
    step(5);
    nsw <= 1'b1;
    clr <= 1'b1;
    step(2);
    nsw <= 1'b0;
    clr <= 1'b0;
    settle(32'h0000_0100);
    // power cycle with a fault that returns afterwards
    d[7] <= 1'b1;
    step(1);
    d[7] <= 1'b0;
    step(5);
    srst <= 1'b1;
    step(3);
    #1;
    chk(fw, 32'h0);
    step(1);
    srst <= 1'b0;
    step(3);
    d[7] <= 1'b1;
    step(1);
    d[7] <= 1'b0;
    step(6);
    #1;
    chk({31'h0, rpt}, 32'h1);
    give_verdict();
  end
endmodule : tb_runtime_fault_status_word
